// ### logic/cawpwm_top.sv
// Wide PWM compare module with its counter and registers
// Assumes special register port and counter tick on mclk
`timescale 1ns/10ps
`include "cawpwm_defines.svh"
module cawpwm_top (
   input  wire logic                     mclk,
   input  wire logic                     rst_n,
   input  wire logic                     cnt_tick,
   input  wire logic                     watchdog_enable_bit,
   input  wire cawpwm_pkg::cawpwm_byte_t sfr_addr,
   input  wire logic                     sfr_wr,
   input  wire logic                     sfr_rd,
   input  wire cawpwm_pkg::cawpwm_byte_t sfr_wdata,
   output cawpwm_pkg::cawpwm_byte_t      sfr_rdata,
   output logic                          module_output_pin
);
   import cawpwm_pkg::*;

   // ****************************************
   // Reset release
   // ****************************************
   logic rst_m_q;
   logic rst_s_q;
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rst_m_q <= 1'b0;
         rst_s_q <= 1'b0;
      end else begin
         rst_m_q <= 1'b1;
         rst_s_q <= rst_m_q;
      end
   end

   // ****************************************
   // Register decode
   // ****************************************
   function automatic logic hit(input cawpwm_byte_t a, input cawpwm_byte_t r);
      hit = (a == r);
   endfunction

   wire wr_cnt_lo = sfr_wr & hit(sfr_addr, `CAW_ADDR_CNT_LO);
   wire wr_cnt_hi = sfr_wr & hit(sfr_addr, `CAW_ADDR_CNT_HI);
   wire wr_ctrl   = sfr_wr & hit(sfr_addr, `CAW_ADDR_CTRL);
   wire wr_mode   = sfr_wr & hit(sfr_addr, `CAW_ADDR_MODE);
   wire wr_cmp_lo = sfr_wr & hit(sfr_addr, `CAW_ADDR_CMP_LO);
   wire wr_cmp_hi = sfr_wr & hit(sfr_addr, `CAW_ADDR_CMP_HI);
   wire rd_cnt_lo = sfr_rd & hit(sfr_addr, `CAW_ADDR_CNT_LO);

   // ****************************************
   // Counter
   // ****************************************
   logic [15:0]  count;
   cawpwm_byte_t snap_hi;
   logic         ovf;
   logic         run_q;

   cawpwm_counter #(
      .CNT_W (16)
   ) u_counter (
      .clk     (mclk),
      .rst_n   (rst_s_q),
      .tick    (cnt_tick),
      .run     (run_q),
      .lock    (watchdog_enable_bit),
      .wr_lo   (wr_cnt_lo),
      .wr_hi   (wr_cnt_hi),
      .rd_lo   (rd_cnt_lo),
      .wdata   (sfr_wdata),
      .count   (count),
      .snap_hi (snap_hi),
      .ovf     (ovf)
   );

   // ****************************************
   // Mode, compare and control state
   // ****************************************
   logic         wide_q;
   logic         cmp_en_q;
   logic         mat_en_q;
   logic         pwm_en_q;
   logic         int_en_q;
   logic         ovf_flag_q;
   logic         match_flag_q;
   logic         out_q;
   cawpwm_word_t cmp_q;

   wire          step     = cnt_tick & run_q;
   wire [15:0]   cnt_next = count + `CAW_CNT_ONE;
   wire          mode_on  = wide_q & pwm_en_q;
   wire          active   = mode_on & cmp_en_q;
   wire          match    = step & active & (cnt_next == cmp_q);
   wire          out_d    = ~active ? 1'b0 :
                            match   ? 1'b1 :
                            ovf     ? 1'b0 : out_q;
   wire          cmp_en_d = wr_cmp_hi ? 1'b1 :
                            wr_cmp_lo ? 1'b0 :
                            wr_mode   ? sfr_wdata[`CAW_MODE_CMP_EN] : cmp_en_q;
   wire          ovf_set  = ovf;
   wire          mat_set  = match & mat_en_q;
   wire          ovf_f_d  = ovf_set |
                            (wr_ctrl ? sfr_wdata[`CAW_CTRL_OVF] & ovf_flag_q : ovf_flag_q);
   wire          mat_f_d  = mat_set |
                            (wr_ctrl ? sfr_wdata[`CAW_CTRL_MATCH] & match_flag_q
                                     : match_flag_q);

   always_ff @(posedge mclk or negedge rst_s_q) begin
      if (!rst_s_q) begin
         wide_q       <= 1'b0;
         cmp_en_q     <= 1'b0;
         mat_en_q     <= 1'b0;
         pwm_en_q     <= 1'b0;
         int_en_q     <= 1'b0;
         run_q        <= 1'b0;
         ovf_flag_q   <= 1'b0;
         match_flag_q <= 1'b0;
         out_q        <= 1'b0;
         cmp_q        <= `CAW_RST_WORD;
      end else begin
         cmp_en_q     <= cmp_en_d;
         ovf_flag_q   <= ovf_f_d;
         match_flag_q <= mat_f_d;
         out_q        <= out_d;
         if (wr_mode) begin
            wide_q   <= sfr_wdata[`CAW_MODE_WIDE];
            mat_en_q <= sfr_wdata[`CAW_MODE_MAT_EN];
            pwm_en_q <= sfr_wdata[`CAW_MODE_PWM_EN];
            int_en_q <= sfr_wdata[`CAW_MODE_INT_EN];
         end
         if (wr_ctrl) begin
            run_q <= sfr_wdata[`CAW_CTRL_RUN];
         end
         if (wr_cmp_lo) begin
            cmp_q[7:0] <= sfr_wdata;
         end
         if (wr_cmp_hi) begin
            cmp_q[15:8] <= sfr_wdata;
         end
      end
   end

   // ****************************************
   // Read data
   // ****************************************
   cawpwm_byte_t mode_rd;
   cawpwm_byte_t ctrl_rd;
   cawpwm_byte_t rd_mux;
   cawpwm_byte_t rdata_q;

   always_comb begin
      mode_rd = `CAW_RST_BYTE;
      mode_rd[`CAW_MODE_WIDE]   = wide_q;
      mode_rd[`CAW_MODE_CMP_EN] = cmp_en_q;
      mode_rd[`CAW_MODE_MAT_EN] = mat_en_q;
      mode_rd[`CAW_MODE_PWM_EN] = pwm_en_q;
      mode_rd[`CAW_MODE_INT_EN] = int_en_q;
      ctrl_rd = `CAW_RST_BYTE;
      ctrl_rd[`CAW_CTRL_OVF]    = ovf_flag_q;
      ctrl_rd[`CAW_CTRL_RUN]    = run_q;
      ctrl_rd[`CAW_CTRL_MATCH]  = match_flag_q;
   end

   assign rd_mux = hit(sfr_addr, `CAW_ADDR_CNT_LO) ? count[7:0] :
                   hit(sfr_addr, `CAW_ADDR_CNT_HI) ? snap_hi :
                   hit(sfr_addr, `CAW_ADDR_CTRL)   ? ctrl_rd :
                   hit(sfr_addr, `CAW_ADDR_MODE)   ? mode_rd :
                   hit(sfr_addr, `CAW_ADDR_CMP_LO) ? cmp_q[7:0] :
                   hit(sfr_addr, `CAW_ADDR_CMP_HI) ? cmp_q[15:8] : `CAW_RST_BYTE;

   always_ff @(posedge mclk or negedge rst_s_q) begin
      if (!rst_s_q) begin
         rdata_q <= `CAW_RST_BYTE;
      end else if (sfr_rd) begin
         rdata_q <= rd_mux;
      end
   end

   assign sfr_rdata         = rdata_q;
   assign module_output_pin = out_q;

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_s_q);

   a_match_drives_high: assert property (match |=> module_output_pin)
      else $error("output not high after match");
   a_ovf_drives_low: assert property (
      ovf && active && !match && !wr_cmp_lo && !wr_mode |=> !module_output_pin)
      else $error("output not low after overflow");
   a_zero_cmp_high: assert property (
      active && cmp_q == `CAW_RST_WORD && ovf |=> module_output_pin)
      else $error("zero compare not held high");
   a_disabled_low: assert property (!cmp_en_q |=> !module_output_pin)
      else $error("output high with comparator off");
   a_mode_gate: assert property (!(wide_q && pwm_en_q) |=> !module_output_pin)
      else $error("output high outside wide mode");
   a_match_flag_set: assert property (match && mat_en_q |=> match_flag_q)
      else $error("match flag not set");
   a_ovf_flag_set: assert property (ovf |=> ovf_flag_q)
      else $error("overflow flag not set");
   a_cmp_lo_clears: assert property (wr_cmp_lo && !wr_cmp_hi |=> !cmp_en_q)
      else $error("compare low write left enable set");
   a_cmp_hi_sets: assert property (wr_cmp_hi |=> cmp_en_q)
      else $error("compare high write left enable clear");
   a_count_step: assert property (
      step && !wr_cnt_lo && !wr_cnt_hi |=> count == $past(cnt_next))
      else $error("counter did not step by one");
   a_lock_holds: assert property (
      (wr_cnt_lo || wr_cnt_hi) && watchdog_enable_bit && !step |=> $stable(count))
      else $error("locked counter was written");
   a_snap_read: assert property (
      rd_cnt_lo ##1 sfr_rd && hit(sfr_addr, `CAW_ADDR_CNT_HI) && !rd_cnt_lo
      |=> sfr_rdata == $past(count[15:8], 2))
      else $error("high byte read not the snapshot");
   a_low_read: assert property (rd_cnt_lo |=> sfr_rdata == $past(count[7:0]))
      else $error("low byte read wrong");
endmodule // cawpwm_top

// ### logic/cawpwm_defines.svh
// Constants for the counter array wide PWM block
// Assumes one system clock and the byte-wide special register port
`ifndef CAWPWM_DEFINES_SVH
`define CAWPWM_DEFINES_SVH

// ****************************************
// Register addresses
// ****************************************
`define CAW_ADDR_CNT_LO   8'hf9
`define CAW_ADDR_CNT_HI   8'hfa
`define CAW_ADDR_CTRL     8'hd8
`define CAW_ADDR_MODE     8'hda
`define CAW_ADDR_CMP_LO   8'hfb
`define CAW_ADDR_CMP_HI   8'hfc

// ****************************************
// Field positions
// ****************************************
`define CAW_CTRL_OVF      7
`define CAW_CTRL_RUN      6
`define CAW_CTRL_MATCH    0
`define CAW_MODE_WIDE     7
`define CAW_MODE_CMP_EN   6
`define CAW_MODE_MAT_EN   3
`define CAW_MODE_PWM_EN   1
`define CAW_MODE_INT_EN   0

// ****************************************
// Reset values and limits
// ****************************************
`define CAW_RST_BYTE      8'h00
`define CAW_RST_WORD      16'h0000
`define CAW_CNT_MAX       16'hffff
`define CAW_CNT_ONE       16'h0001

`endif

// ### logic/cawpwm_pkg.sv
// Types shared by the counter array wide PWM block
// Assumes the defines header is compiled alongside
package cawpwm_pkg;
   typedef logic [7:0]  cawpwm_byte_t;
   typedef logic [15:0] cawpwm_word_t;
endpackage

// ### logic/cawpwm_counter.sv
// Sixteen-bit counter with byte writes, lock and high byte snapshot
// Assumes tick is a one-cycle enable on the same clock
`timescale 1ns/10ps
`include "cawpwm_defines.svh"
module cawpwm_counter #(
   parameter int CNT_W = 16
) (
   input  wire logic                   clk,
   input  wire logic                   rst_n,
   input  wire logic                   tick,
   input  wire logic                   run,
   input  wire logic                   lock,
   input  wire logic                   wr_lo,
   input  wire logic                   wr_hi,
   input  wire logic                   rd_lo,
   input  wire cawpwm_pkg::cawpwm_byte_t wdata,
   output logic [CNT_W-1:0]            count,
   output cawpwm_pkg::cawpwm_byte_t    snap_hi,
   output logic                        ovf
);
   import cawpwm_pkg::*;

   if (CNT_W != 16) begin : g_bad_width
      $error("cawpwm_counter needs CNT_W of 16");
   end

   logic [CNT_W-1:0] cnt_q;
   logic [CNT_W-1:0] cnt_d;
   cawpwm_byte_t     snap_q;
   logic             step;
   logic             wr_lo_ok;
   logic             wr_hi_ok;

   // ****************************************
   // Next count
   // ****************************************
   assign step     = tick & run;
   assign wr_lo_ok = wr_lo & ~lock;
   assign wr_hi_ok = wr_hi & ~lock;
   assign ovf      = step & (cnt_q == `CAW_CNT_MAX);
   assign cnt_d    = wr_lo_ok ? {cnt_q[15:8], wdata} :
                     wr_hi_ok ? {wdata, cnt_q[7:0]} :
                     step     ? cnt_q + `CAW_CNT_ONE : cnt_q;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q  <= `CAW_RST_WORD;
         snap_q <= `CAW_RST_BYTE;
      end else begin
         cnt_q <= cnt_d;
         if (rd_lo) begin
            snap_q <= cnt_q[15:8];
         end
      end
   end

   assign count   = cnt_q;
   assign snap_hi = snap_q;
endmodule // cawpwm_counter

// ### test/cawpwm_load.sv
// Load model on the wide PWM output pin
// Assumes the pin is sampled on mclk with one counter tick per cycle
`timescale 1ns/10ps
module cawpwm_load (
   input  wire logic   mclk,
   input  wire logic   pin,
   output logic [16:0] hi_len,
   output logic        hi_done,
   output int          pulses
);
   logic [16:0] run_len;
   initial begin
      run_len = '0;
      hi_len = '0;
      hi_done = 1'b0;
      pulses = 0;
   end
   // ****************************************
   // Measure each high pulse
   // ****************************************
   always @(posedge mclk) begin
      hi_done <= 1'b0;
      if (pin) begin
         run_len <= run_len + 17'h0_0001;
      end else if (run_len != '0) begin
         hi_len <= run_len;
         hi_done <= 1'b1;
         pulses <= pulses + 1;
         run_len <= '0;
      end
   end
endmodule // cawpwm_load

// ### test/tb_counter_array_wide_pwm.sv
// Self-checking bench for the wide PWM block
// Assumes the design package, defines header and load model are compiled first
`timescale 1ns/10ps
`include "cawpwm_defines.svh"
module tb_counter_array_wide_pwm;
   import cawpwm_pkg::*;
   logic         mclk, rst_n, cnt_tick, watchdog_enable_bit, sfr_wr, sfr_rd;
   logic         module_output_pin, hi_done, rd_seen;
   cawpwm_byte_t sfr_addr, sfr_wdata, sfr_rdata, rnd;
   logic [16:0]  hi_len;
   logic [16:0]  rq[$];
   logic [16:0]  pq[$];
   int           err_count = 0;
   int           checks_done = 0;
   int           pulses;

   cawpwm_top dut (.mclk(mclk), .rst_n(rst_n), .cnt_tick(cnt_tick),
      .watchdog_enable_bit(watchdog_enable_bit), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
      .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
      .module_output_pin(module_output_pin));
   cawpwm_load load (.mclk(mclk), .pin(module_output_pin), .hi_len(hi_len),
      .hi_done(hi_done), .pulses(pulses));

   // ****************************************
   // Shared tasks
   // ****************************************
   task automatic chk(input logic [16:0] seen, input logic [16:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_count++;
         $display("BAD %0t got %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic acc(input logic w, input cawpwm_byte_t a, input cawpwm_byte_t d);
      @(posedge mclk);
      #1;
      sfr_addr = a;
      sfr_wdata = d;
      sfr_wr = w;
      sfr_rd = !w;
      @(posedge mclk);
      #1;
      sfr_wr = 1'b0;
      sfr_rd = 1'b0;
   endtask
   task automatic wr(input cawpwm_byte_t a, input cawpwm_byte_t d);
      acc(1'b1, a, d);
   endtask
   task automatic rd(input cawpwm_byte_t a, input cawpwm_byte_t e);
      rq.push_back({9'h000, e});
      acc(1'b0, a, 8'h00);
   endtask
   task automatic rd2(input cawpwm_byte_t e_lo, input cawpwm_byte_t e_hi);
      rq.push_back({9'h000, e_lo});
      rq.push_back({9'h000, e_hi});
      @(posedge mclk);
      #1;
      sfr_addr = `CAW_ADDR_CNT_LO;
      sfr_rd = 1'b1;
      @(posedge mclk);
      #1;
      sfr_addr = `CAW_ADDR_CNT_HI;
      @(posedge mclk);
      #1;
      sfr_rd = 1'b0;
   endtask
   task automatic conclude;
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // ****************************************
   // Clock, monitor and watchdog
   // ****************************************
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   initial begin
      rd_seen = 1'b0;
   end
   always @(posedge mclk) begin
      if (rd_seen) chk({9'h000, sfr_rdata}, rq.pop_front());
      if (hi_done) chk(hi_len, pq.pop_front());
      rd_seen <= sfr_rd;
   end
   initial begin
      #900_000;
      err_count++;
      conclude();
   end

   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      rst_n = 1'b0;
      cnt_tick = 1'b0;
      watchdog_enable_bit = 1'b0;
      sfr_addr = 8'h00;
      sfr_wdata = 8'h00;
      sfr_wr = 1'b0;
      sfr_rd = 1'b0;
      void'($urandom(44));
      repeat (3) @(posedge mclk);
      #1 rst_n = 1'b1;
      repeat (3) @(posedge mclk);
      #1 cnt_tick = 1'b1;
      rd(`CAW_ADDR_CNT_LO, 8'h00);
      rd(`CAW_ADDR_CNT_HI, 8'h00);
      wr(`CAW_ADDR_CNT_LO, 8'h34);
      wr(`CAW_ADDR_CNT_HI, 8'h12);
      rd(`CAW_ADDR_CNT_HI, 8'h00);
      rd(`CAW_ADDR_CNT_LO, 8'h34);
      rd(`CAW_ADDR_CNT_HI, 8'h12);
      watchdog_enable_bit = 1'b1;
      rnd = cawpwm_byte_t'($urandom);
      wr(`CAW_ADDR_CNT_LO, rnd);
      wr(`CAW_ADDR_CNT_HI, ~rnd);
      rd(`CAW_ADDR_CNT_LO, 8'h34);
      rd(`CAW_ADDR_CNT_HI, 8'h12);
      rd2(8'h34, 8'h12);
      watchdog_enable_bit = 1'b0;
      // Comparator enable follows compare byte writes
      wr(`CAW_ADDR_MODE, 8'hca);
      wr(`CAW_ADDR_CMP_LO, 8'hf8);
      rd(`CAW_ADDR_MODE, 8'h8a);
      wr(`CAW_ADDR_CMP_HI, 8'hff);
      rd(`CAW_ADDR_MODE, 8'hca);
      // Disabled comparator runs through match and wrap with pin low
      wr(`CAW_ADDR_CMP_LO, 8'hf8);
      wr(`CAW_ADDR_CNT_LO, 8'he0);
      wr(`CAW_ADDR_CNT_HI, 8'hff);
      wr(`CAW_ADDR_CTRL, 8'h40);
      repeat (64) @(posedge mclk);
      chk(pulses[16:0], 17'h0_0000);
      wr(`CAW_ADDR_CTRL, 8'h00);
      wr(`CAW_ADDR_CNT_LO, 8'hf0);
      wr(`CAW_ADDR_CNT_HI, 8'hff);
      wr(`CAW_ADDR_CMP_HI, 8'hff);
      wr(`CAW_ADDR_MODE, 8'hca | (rnd & 8'h34));
      pq.push_back(17'h0_0008);
      wr(`CAW_ADDR_CTRL, 8'h40);
      repeat (40) @(posedge mclk);
      rd(`CAW_ADDR_CTRL, 8'hc1);
      wr(`CAW_ADDR_CMP_LO, 8'h00);
      wr(`CAW_ADDR_CMP_HI, 8'hff);
      pq.push_back(17'h0_0100);
      for (int i = 0; i < 70000 && pq.size() > 0; i++) @(posedge mclk);
      repeat (2) @(posedge mclk);
      chk(pulses[16:0], 17'h0_0002);
      chk(17'(pq.size()), 17'h0_0000);
      // Zero compare keeps the pin high through the wrap
      wr(`CAW_ADDR_CNT_HI, 8'hff);
      wr(`CAW_ADDR_CNT_LO, 8'hf0);
      wr(`CAW_ADDR_CMP_LO, 8'h00);
      wr(`CAW_ADDR_CMP_HI, 8'h00);
      repeat (30) @(posedge mclk);
      chk({16'h0000, module_output_pin}, 17'h0_0001);
      conclude();
   end
endmodule // tb_counter_array_wide_pwm
